// ===== common/chan_switch_pkg.sv
// constants and carriers for the i2c channel switch
// assumes a 100 MHz system clock sampling the upstream bus
package chan_switch_pkg;
  localparam int          NUM_CHAN      = 8;
  localparam int          NUM_STRAP     = 3;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [3:0]  ADDR_FIXED    = 4'he;
  localparam int          BYTE_BITS     = 8;
  localparam logic [3:0]  LAST_BIT_IDX  = 4'h7;
  localparam logic [3:0]  ZERO_BIT_IDX  = 4'h0;

  // sampled upstream bus events, one system clock wide; sda is the sampled level
  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
  } bus_evt_s;
endpackage

// ===== design/bus_sampler.sv
// bus_sampler: synchronises upstream scl/sda and finds bus events
// assumes both pins are asynchronous to clk_in
`timescale 1ns/1ps
module bus_sampler (
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output chan_switch_pkg::bus_evt_s      evt_out
);
  import chan_switch_pkg::*;

  logic [1:0] scl_sync_ff, nxt_scl_sync;
  logic [1:0] sda_sync_ff, nxt_sda_sync;
  logic       scl_old_ff,  nxt_scl_old;
  logic       sda_old_ff,  nxt_sda_old;
  bus_evt_s   evt_ff,      nxt_evt;

  always_comb begin
    // first stage read only by the second stage
    nxt_scl_sync = {scl_sync_ff[0], scl_in};
    nxt_sda_sync = {sda_sync_ff[0], sda_in};
    nxt_scl_old  = scl_sync_ff[1];
    nxt_sda_old  = sda_sync_ff[1];
    nxt_evt.sda      = sda_sync_ff[1];
    nxt_evt.scl_rise = scl_sync_ff[1] & ~scl_old_ff;
    nxt_evt.scl_fall = ~scl_sync_ff[1] & scl_old_ff;
    nxt_evt.start    = scl_sync_ff[1] & scl_old_ff
                       & sda_old_ff & ~sda_sync_ff[1];
    nxt_evt.stop     = scl_sync_ff[1] & scl_old_ff
                       & ~sda_old_ff & sda_sync_ff[1];
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_old_ff  <= 1'b1;
      sda_old_ff  <= 1'b1;
      evt_ff      <= '0;
    end else begin
      scl_sync_ff <= nxt_scl_sync;
      sda_sync_ff <= nxt_sda_sync;
      scl_old_ff  <= nxt_scl_old;
      sda_old_ff  <= nxt_sda_old;
      evt_ff      <= nxt_evt;
    end
  end

  assign evt_out = evt_ff;
endmodule

// ===== design/chan_switch.sv
// chan_switch: i2c slave holding an 8-bit channel enable mask
// assumes upstream scl/sda are asynchronous pins, open drain;
// downstream connection is done by analog pass gates steered by
// chan_connect_out
// Summary of operation
// - byte after own address ack is stored
// - mask writable and readable over i2c
// - each mask bit enables one channel
// - any number of channels may be enabled
// - new selection connects only after stop
// - several bytes written: last one kept
// - all channels off at power up
// - straps set low address bits
// - disabled channels stay isolated from upstream
`timescale 1ns/1ps
module chan_switch #(
  parameter int N_CHAN  = chan_switch_pkg::NUM_CHAN,
  parameter int N_STRAP = chan_switch_pkg::NUM_STRAP
) (
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_oe_n_out,
  input  wire logic [N_STRAP-1:0]    addr_strap_in,
  output logic [N_CHAN-1:0]          chan_connect_out,
  output logic [N_CHAN-1:0]          channel_enable_mask_out
);
  import chan_switch_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WRB  = 3'b011,
    ST_WACK = 3'b100,
    ST_RDB  = 3'b101,
    ST_RACK = 3'b110
  } slv_state_e;

  bus_evt_s            evt;
  slv_state_e          st_ff,     nxt_st;
  logic [3:0]          bit_ff,    nxt_bit;
  logic [7:0]          shift_ff,  nxt_shift;
  logic [N_CHAN-1:0]   mask_ff,   nxt_mask;
  logic [N_CHAN-1:0]   conn_ff,   nxt_conn;
  logic                pend_ff,   nxt_pend;
  logic                oe_n_ff,   nxt_oe_n;
  logic [N_STRAP-1:0]  strap_ff,  nxt_strap;
  logic                strap_ok_ff, nxt_strap_ok;
  logic [N_STRAP-1:0]  strap_meta_ff, nxt_strap_meta;
  logic [N_STRAP-1:0]  strap_sync_ff, nxt_strap_sync;
  logic [6:0]          own_addr;

  bus_sampler u_sampler (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .evt_out (evt)
  );

  // fixed upper bits, straps fill the low ones
  assign own_addr = {ADDR_FIXED[3:0], {(3 - N_STRAP){1'b0}}, strap_ff};

  always_comb begin
    nxt_st       = st_ff;
    nxt_bit      = bit_ff;
    nxt_shift    = shift_ff;
    nxt_mask     = mask_ff;
    nxt_conn     = conn_ff;
    nxt_pend     = pend_ff;
    nxt_oe_n     = oe_n_ff;
    // straps are pins: two flops before any logic reads them
    nxt_strap_meta = addr_strap_in;
    nxt_strap_sync = strap_meta_ff;
    // straps caught once after reset release
    nxt_strap    = strap_ok_ff ? strap_ff : strap_sync_ff;
    nxt_strap_ok = 1'b1;
    if (evt.stop) begin
      nxt_st   = ST_IDLE;
      nxt_oe_n = 1'b1;
      if (pend_ff) begin
        nxt_conn = mask_ff;
        nxt_pend = 1'b0;
      end
    end else if (evt.start) begin
      // repeated start too; bus assumed idle first
      nxt_st   = ST_ADDR;
      nxt_bit  = ZERO_BIT_IDX;
      nxt_oe_n = 1'b1;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (evt.scl_rise) begin
            nxt_shift = {shift_ff[6:0], evt.sda};
            nxt_bit   = bit_ff + 4'h1;
          end else if (evt.scl_fall && bit_ff == LAST_BIT_IDX + 4'h1) begin
            if (shift_ff[7:1] == own_addr) begin
              nxt_st   = ST_AACK;
              nxt_oe_n = 1'b0;
            end else begin
              nxt_st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (evt.scl_fall) begin
            nxt_bit = ZERO_BIT_IDX;
            if (shift_ff[0]) begin
              nxt_st    = ST_RDB;
              nxt_shift = {{(8 - N_CHAN){1'b0}}, mask_ff};
              nxt_oe_n  = mask_ff[N_CHAN-1];
            end else begin
              nxt_st   = ST_WRB;
              nxt_oe_n = 1'b1;
            end
          end
        end
        ST_WRB: begin
          if (evt.scl_rise) begin
            nxt_shift = {shift_ff[6:0], evt.sda};
            nxt_bit   = bit_ff + 4'h1;
          end else if (evt.scl_fall && bit_ff == LAST_BIT_IDX + 4'h1) begin
            // each new byte overwrites, last one wins
            nxt_mask = shift_ff[N_CHAN-1:0];
            nxt_pend = 1'b1;
            nxt_st   = ST_WACK;
            nxt_oe_n = 1'b0;
          end
        end
        ST_WACK: begin
          // ack driven; scl fall returns to ST_WRB for another byte
          if (evt.scl_fall) begin
            nxt_st   = ST_WRB;
            nxt_bit  = ZERO_BIT_IDX;
            nxt_oe_n = 1'b1;
          end
        end
        ST_RDB: begin
          if (evt.scl_fall) begin
            if (bit_ff == LAST_BIT_IDX) begin
              nxt_st   = ST_RACK;
              nxt_oe_n = 1'b1;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_bit   = bit_ff + 4'h1;
              nxt_oe_n  = shift_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (evt.scl_rise) begin
            nxt_shift[0] = evt.sda;
          end else if (evt.scl_fall) begin
            nxt_bit = ZERO_BIT_IDX;
            if (shift_ff[0]) begin
              nxt_st = ST_IDLE; // nack ends the read
            end else begin
              nxt_st    = ST_RDB;
              nxt_shift = {{(8 - N_CHAN){1'b0}}, mask_ff};
              nxt_oe_n  = mask_ff[N_CHAN-1];
            end
          end
        end
        default: begin
          nxt_st   = ST_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    // synchroniser left unreset so it is full when reset lifts
    strap_meta_ff <= nxt_strap_meta;
    strap_sync_ff <= nxt_strap_sync;
    if (srst_in) begin
      st_ff       <= ST_IDLE;
      bit_ff      <= ZERO_BIT_IDX;
      shift_ff    <= '0;
      mask_ff     <= MASK_RESET[N_CHAN-1:0];
      conn_ff     <= MASK_RESET[N_CHAN-1:0];
      pend_ff     <= 1'b0;
      oe_n_ff     <= 1'b1;
      strap_ff    <= '0;
      strap_ok_ff <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      bit_ff      <= nxt_bit;
      shift_ff    <= nxt_shift;
      mask_ff     <= nxt_mask;
      conn_ff     <= nxt_conn;
      pend_ff     <= nxt_pend;
      oe_n_ff     <= nxt_oe_n;
      strap_ff    <= nxt_strap;
      strap_ok_ff <= nxt_strap_ok;
    end
  end

  // zero bits keep pass gates open, isolating channels
  assign chan_connect_out        = conn_ff;
  assign channel_enable_mask_out = mask_ff;
  assign sda_oe_n_out            = oe_n_ff;
endmodule

// ===== testbench/chan_switch_assertions.sv
// checker: bus and channel timing at the switch ports
// assumes sda_in is the resolved open-drain line
`timescale 1ns/1ps
module chan_switch_assertions #(
  parameter int N_CHAN  = 8,
  parameter int N_STRAP = 3
) (
  input wire logic               clk_in,
  input wire logic               srst_in,
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_oe_n_out,
  input wire logic [N_STRAP-1:0] addr_strap_in,
  input wire logic [N_CHAN-1:0]  chan_connect_out,
  input wire logic [N_CHAN-1:0]  channel_enable_mask_out
);
  wire logic [N_CHAN-1:0] cn = chan_connect_out;
  wire logic [N_CHAN-1:0] mk = channel_enable_mask_out;
  wire logic              oe = sda_oe_n_out;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  chk_reset_clear:
    assert property ($fell(srst_in) |-> !cn && !mk && oe) else $error("rst");
  chk_conn_idle:
    assert property ($changed(cn) |-> scl_in && sda_in) else $error("busy");
  chk_conn_mask:
    assert property ($changed(cn) |-> cn == mk) else $error("conn");
  chk_conn_stop:
    assert property ($rose(sda_in) && scl_in |-> ##[1:8] cn == mk)
    else $error("stop");
  chk_conn_hold:
    assert property (!(scl_in && sda_in) |=> $stable(cn)) else $error("hold");
  chk_oe_scl_low:
    assert property ($changed(oe) |-> !scl_in) else $error("sda");
  chk_oe_release:
    assert property (!oe |-> ##[1:130] oe) else $error("stuck");
  chk_mask_acked:
    assert property ($changed(mk) |-> ##[0:12] !oe) else $error("ack");
endmodule
bind chan_switch chan_switch_assertions #(
  .N_CHAN  (N_CHAN),
  .N_STRAP (N_STRAP)
) i_chan_switch_assertions (
  .clk_in                  (clk_in),
  .srst_in                 (srst_in),
  .scl_in                  (scl_in),
  .sda_in                  (sda_in),
  .sda_oe_n_out            (sda_oe_n_out),
  .addr_strap_in           (addr_strap_in),
  .chan_connect_out        (chan_connect_out),
  .channel_enable_mask_out (channel_enable_mask_out)
);

// ===== testbench/i2c_master_model.sv
// i2c master for the upstream bus, open drain on sda
// assumes a pull-up on sda; scl stands high while idle
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // quarter bit of 3 clocks; every second bit one more low clock,
  // so scl averages the 125 ns bus period
  task automatic drv(input logic c, input logic d);
    scl_out <= c;
    sda_out <= d;
    repeat (3) @(posedge clk_in);
  endtask
  // p high: start from idle, low: stop right after the ack
  task automatic frame(input logic p);
    drv(p, p);
    drv(1'b1, 1'b0);
    drv(!p, !p);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      drv(1'b0, d[i]);
      drv(1'b1, d[i]);
      r[i] = sda_in;
      drv(1'b1, d[i]);
      drv(1'b0, d[i]);
      if (i[0]) @(posedge clk_in);
    end
  endtask
endmodule

// ===== testbench/chan_switch_tb.sv
// bench: masks written, read back, switched in at stop
// assumes the master model and the bound checker
`timescale 1ns/1ps
module chan_switch_tb;
  import chan_switch_pkg::*;
  logic       clk_in = 1'b0;
  logic       srst_in = 1'b1;
  logic [2:0] strap = 3'h0;
  logic [7:0] conn, mask, v, p;
  logic [8:0] r;
  logic       scl, sda_m, oe_n;
  wire        sda = sda_m & oe_n;
  integer     seed = 32'h1c1c, fail_count = 0, check_count = 0;
  always #5 clk_in = ~clk_in;
  chan_switch i_chan_switch (.clk_in, .srst_in, .scl_in(scl),
    .sda_in(sda), .sda_oe_n_out(oe_n), .addr_strap_in(strap),
    .chan_connect_out(conn), .channel_enable_mask_out(mask));
  i2c_master_model i_i2c_master_model (.clk_in, .sda_in(sda),
    .scl_out(scl), .sda_out(sda_m));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] ack_of(input logic [2:0] s);
    return {7'h0, s !== strap};
  endfunction
  task automatic head(input logic [2:0] s, input logic rd);
    i_i2c_master_model.frame(1'b1);
    i_i2c_master_model.xfer({ADDR_FIXED, s, rd, 1'b1}, r);
    chk(8'(r[0]), ack_of(s));
  endtask
  task automatic x(input logic [7:0] b);
    i_i2c_master_model.xfer({b, 1'b1}, r);
  endtask
  task automatic stp;
    i_i2c_master_model.frame(1'b0);
    repeat (6) @(posedge clk_in);
  endtask
  // reset held 12 clocks; traffic waits for the strap capture
  task automatic rst;
    srst_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(conn, 8'h00);
    chk(mask, MASK_RESET);
  endtask
  initial begin
    strap <= 3'($random(seed));
    rst;
    p = 8'h00;
    for (int i = 0; i < 12; i++) begin
      v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($random(seed));
      head(strap, 1'b0);
      if (i[0]) x(~v);
      x(v);
      chk(8'(r[0]), 8'h00);
      chk(mask, v);
      chk(conn, p);
      stp;
      chk(conn, v);
      // refused address, then a repeated start for the read
      head(strap ^ 3'h1, 1'b0);
      head(strap, 1'b1);
      // even passes ack the byte and read the mask once more
      i_i2c_master_model.xfer({8'hff, i[0]}, r);
      chk(r[8:1], v);
      if (!i[0]) begin
        x(8'hff);
        chk(r[8:1], v);
      end
      stp;
      p = v;
    end
    // second reset with channels on: all must drop
    rst;
    give_verdict;
  end
  initial begin
    #300us;
    fail_count++;
    give_verdict;
  end
endmodule
